// File: dbg_pin_pkg.sv
// Constants for the debug pin, break trigger and shutdown timer block.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package dbg_pin_pkg;
   localparam int unsigned SYS_CLK_HZ        = 50_000_000;
   localparam int unsigned SHUTDOWN_TIME_S   = 4;
   localparam int unsigned SHUTDOWN_CYCLES   = SHUTDOWN_TIME_S * SYS_CLK_HZ;
   localparam int unsigned TRIG_PULSE_NS     = 160;
   localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TMR_W             = 28;
   localparam int unsigned CNT_W             = 8;

   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
   localparam logic [7:0] OFS_TMR_CLEAR = 8'h10;

   localparam int CTRL_BRK_OUT   = 0;
   localparam int CTRL_BRK_EN    = 1;
   localparam int CTRL_HOLD_EN   = 2;
   localparam int CTRL_FIR_EN    = 3;
   localparam int CTRL_RST_KIND  = 4;
   localparam int CTRL_RST_REL   = 5;
   localparam int CTRL_RST_FORCE = 6;
   localparam int TMR_CLEAR_BIT  = 0;

   localparam int ST_DBG_EN     = 0;
   localparam int ST_RESET_MODE_SEL_N      = 1;
   localparam int ST_DBG_RST    = 2;
   localparam int ST_BRK_PEND   = 3;
   localparam int ST_EVT_PEND   = 4;
   localparam int ST_FIR        = 5;
   localparam int ST_SHUTDOWN   = 6;
   localparam int ST_STRAP_DONE = 7;

   localparam int EV_BREAK = 0;
   localparam int EV_TRIG  = 1;
   localparam int EV_SHUT  = 2;
   localparam int EV_W     = 3;

   localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

   typedef enum logic [2:0] {
      TRG_IDLE = 3'b001,
      TRG_LOW  = 3'b010,
      TRG_GAP  = 3'b100
   } trg_state_t;
endpackage

// File: debug_pin_break_trigger.sv
// Pin logic of the serial debug port: shared data/reset-mode pin, break/trigger pin,
// hold-acknowledge/debug-enable strap and the power-on shutdown timer, with an APB slave.
// Assumes pins arrive asynchronously and core-side signals are on SYS_CLK.
`timescale 1ns/10ps
module debug_pin_break_trigger #(
   parameter int unsigned SHUTDOWN_CYCLES_P = dbg_pin_pkg::SHUTDOWN_CYCLES
) (
   input  wire logic                        SYS_CLK,
   input  wire logic                        NRST,
   input  wire logic                        PSEL,
   input  wire logic                        PENABLE,
   input  wire logic                        PWRITE,
   input  wire logic [7:0]                  PADDR,
   input  wire logic [31:0]                 PWDATA,
   output logic      [31:0]                 PRDATA,
   output logic                             PREADY,
   output logic                             PSLVERR,
   output logic                             IRQ,
   input  wire logic                        RTC_RESET_N,
   input  wire logic                        DBG_SERIAL_CLK,
   input  wire logic                        DBG_MODE_SELECT,
   input  wire logic                        DBG_SERIAL_IN,
   input  wire logic                        DBG_UNIT_RESET_N,
   input  wire logic                        BREAK_TRIGGER_IO_N_I,
   output logic                             BREAK_TRIGGER_IO_N_O,
   output logic                             BREAK_TRIGGER_IO_N_OE,
   input  wire logic                        DBG_ENABLE_STRAP,
   output logic                             HOLD_ACK_N_O,
   output logic                             HOLD_ACK_N_OE,
   input  wire logic                        HOLD_GRANT,
   input  wire logic                        DBG_SERIAL_OUT,
   input  wire logic                        IR_TX_DATA,
   output logic                             INFRARED_DATA_OUT,
   input  wire logic                        DEBUG_MODE,
   input  wire logic                        BREAKPOINT_MATCH,
   output logic                             BREAK_REQ,
   output logic                             CORE_COLD_RESET_REQ,
   output logic                             CORE_SOFT_RESET_REQ,
   output logic                             SHUTDOWN_REQ,
   output logic                             DBG_UNIT_ACTIVE,
   output logic                             FIR_ACTIVE,
   output logic                             DBG_SAMPLE_VALID,
   output logic                             DBG_SAMPLE_MODE,
   output logic                             DBG_SAMPLE_DATA
);
   import dbg_pin_pkg::*;

   if (SHUTDOWN_CYCLES_P < 1 || SHUTDOWN_CYCLES_P >= (64'd1 << TMR_W))
      $error("SHUTDOWN_CYCLES_P out of range");
   if (TRIG_PULSE_CYCLES < 1 || TRIG_PULSE_CYCLES > (1 << CNT_W))
      $error("Trigger pulse count out of range");

   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SHUTDOWN_CYCLES_P - 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TRIG_PULSE_CYCLES - 1);

   typedef struct packed {
      logic             pready, pslverr;
      logic [31:0]      prdata;
      logic [2:0]       ck, bk, rtc;
      logic [1:0]       ms, di, ur, en;
      logic             brk_dir_out, brk_en, hold_en, fir_en, rst_kind;
      logic             strap_done;
      logic             dbg_enabled;
      logic             dbg_use;
      logic             unit_active;
      logic             fir_active;
      logic             reset_mode;
      logic             dbg_rst;
      logic             cold_req, soft_req;
      logic             dbg_mode_prev;
      logic             brk_pend;
      logic             brk_req;
      trg_state_t       trg_state;
      logic [CNT_W-1:0] trg_cnt;
      logic             evt_pend;
      logic             trg_o, trg_oe;
      logic             smp_valid, smp_mode, smp_data;
      logic [TMR_W-1:0] tmr;
      logic             shutdown;
      logic [EV_W-1:0]  irq_stat;
      logic [EV_W-1:0]  irq_mask;
      logic             irq;
      logic             ir_out;
      logic             hold_o, hold_oe;
   } state_t;

   localparam state_t ST_RESET = '{trg_state: TRG_IDLE, trg_o: 1'b1, hold_o: 1'b1,
                                   irq_mask: IRQ_MASK_RESET, default: '0};

   state_t st_ff;
   state_t nxt_st;

   always_comb
   begin
      logic            setup;
      logic            wr;
      logic            brk_in_mode;
      logic            brk_fall;
      logic            hit;
      logic [EV_W-1:0] ev;
      logic [31:0]     rd;
      logic            mapped;
      setup = PSEL & ~PENABLE;
      wr = PSEL & PENABLE & PWRITE & st_ff.pready;
      ev = '0;
      rd = '0;
      mapped = 1'b1;
      brk_in_mode = st_ff.unit_active & ~st_ff.brk_dir_out & st_ff.brk_en;
      brk_fall = ~st_ff.bk[1] & st_ff.bk[2];
      hit = BREAKPOINT_MATCH & ~DEBUG_MODE & st_ff.trg_oe;
      nxt_st = st_ff;
      nxt_st.ck = {st_ff.ck[1:0], DBG_SERIAL_CLK};
      nxt_st.ms = {st_ff.ms[0], DBG_MODE_SELECT};
      nxt_st.di = {st_ff.di[0], DBG_SERIAL_IN};
      nxt_st.ur = {st_ff.ur[0], DBG_UNIT_RESET_N};
      nxt_st.bk = {st_ff.bk[1:0], BREAK_TRIGGER_IO_N_I};
      nxt_st.rtc = {st_ff.rtc[1:0], RTC_RESET_N};
      nxt_st.en = {st_ff.en[0], DBG_ENABLE_STRAP};

      if (wr && PADDR == OFS_CTRL)
      begin
         nxt_st.brk_dir_out = PWDATA[CTRL_BRK_OUT];
         nxt_st.brk_en = PWDATA[CTRL_BRK_EN];
         nxt_st.hold_en = PWDATA[CTRL_HOLD_EN];
         nxt_st.fir_en = PWDATA[CTRL_FIR_EN];
         nxt_st.rst_kind = PWDATA[CTRL_RST_KIND];
      end
      if (wr && PADDR == OFS_IRQ_MASK)
         nxt_st.irq_mask = PWDATA[EV_W-1:0];

      nxt_st.dbg_use = st_ff.dbg_enabled & ~st_ff.fir_en;
      nxt_st.fir_active = st_ff.fir_en;
      // unit runs only out of its own reset.
      nxt_st.unit_active = st_ff.dbg_use & st_ff.ur[1];
      nxt_st.ir_out = st_ff.dbg_use ? DBG_SERIAL_OUT : IR_TX_DATA;

      // reset-mode sampling while unit reset is held.
      if (!st_ff.ur[1])
      begin
         nxt_st.reset_mode = st_ff.di[1];
         nxt_st.dbg_rst = ~st_ff.di[1];
      end
      else if (wr && PADDR == OFS_CTRL && PWDATA[CTRL_RST_FORCE])
         nxt_st.dbg_rst = 1'b1;
      else if (wr && PADDR == OFS_CTRL && PWDATA[CTRL_RST_REL])
         nxt_st.dbg_rst = 1'b0;
      // debug reset kind steers cold or soft request.
      nxt_st.cold_req = st_ff.dbg_rst & st_ff.dbg_use & ~st_ff.rst_kind;
      nxt_st.soft_req = st_ff.dbg_rst & st_ff.dbg_use & st_ff.rst_kind;

      // serial data and mode taken on link clock rising edges.
      nxt_st.smp_valid = st_ff.unit_active & st_ff.ck[1] & ~st_ff.ck[2];
      nxt_st.smp_mode = st_ff.ms[1];
      nxt_st.smp_data = st_ff.di[1];

      nxt_st.dbg_mode_prev = DEBUG_MODE;
      if (DEBUG_MODE && !st_ff.dbg_mode_prev)
         nxt_st.brk_pend = 1'b0;
      // a request seen in debug mode waits for normal mode.
      if (brk_in_mode && brk_fall)
      begin
         nxt_st.brk_pend = 1'b1;
         ev[EV_BREAK] = 1'b1;
      end
      // request reaches the core only in normal mode.
      nxt_st.brk_req = nxt_st.brk_pend & ~DEBUG_MODE;

      nxt_st.trg_oe = st_ff.unit_active & st_ff.brk_dir_out;
      nxt_st.trg_o = 1'b1;
      // debug mode holds the pin low and drops pending events.
      if (DEBUG_MODE)
      begin
         nxt_st.trg_state = TRG_IDLE;
         nxt_st.evt_pend = 1'b0;
         nxt_st.trg_cnt = '0;
         nxt_st.trg_o = 1'b0;
      end
      else
      begin
         unique case (st_ff.trg_state)
            // one low pulse per match or merged group.
            TRG_IDLE:
               if (hit || st_ff.evt_pend)
               begin
                  nxt_st.trg_state = TRG_LOW;
                  nxt_st.trg_cnt = CNT_LAST;
                  nxt_st.evt_pend = 1'b0;
                  nxt_st.trg_o = 1'b0;
                  ev[EV_TRIG] = 1'b1;
               end
            TRG_LOW:
            begin
               nxt_st.trg_o = 1'b0;
               if (hit)
                  nxt_st.evt_pend = 1'b1;
               if (st_ff.trg_cnt == '0)
               begin
                  nxt_st.trg_state = TRG_GAP;
                  nxt_st.trg_cnt = CNT_LAST;
                  nxt_st.trg_o = 1'b1;
               end
               else
                  nxt_st.trg_cnt = st_ff.trg_cnt - 1'b1;
            end
            TRG_GAP:
            begin
               // matches during the recovery gap merge too.
               if (hit)
                  nxt_st.evt_pend = 1'b1;
               if (st_ff.trg_cnt == '0)
                  nxt_st.trg_state = TRG_IDLE;
               else
                  nxt_st.trg_cnt = st_ff.trg_cnt - 1'b1;
            end
            default:
               nxt_st.trg_state = TRG_IDLE;
         endcase
      end

      if (!st_ff.rtc[1])
      begin
         nxt_st.strap_done = 1'b0;
         nxt_st.dbg_enabled = 1'b0;
         nxt_st.tmr = '0;
         nxt_st.shutdown = 1'b0;
      end
      else
      begin
         // strap captured once at reset release.
         if (!st_ff.rtc[2])
         begin
            nxt_st.strap_done = 1'b1;
            nxt_st.dbg_enabled = st_ff.en[1];
         end
         // shutdown timer runs when strap is 0.
         if (st_ff.strap_done && !st_ff.dbg_enabled && !st_ff.shutdown)
         begin
            if (wr && PADDR == OFS_TMR_CLEAR && PWDATA[TMR_CLEAR_BIT])
               nxt_st.tmr = '0;
            else if (st_ff.tmr == TMR_LAST)
            begin
               nxt_st.shutdown = 1'b1;
               ev[EV_SHUT] = 1'b1;
            end
            else
               nxt_st.tmr = st_ff.tmr + 1'b1;
         end
      end

      // hold acknowledge drives only when enabled after the strap.
      nxt_st.hold_oe = st_ff.strap_done & st_ff.hold_en;
      nxt_st.hold_o = ~HOLD_GRANT;

      if (wr && PADDR == OFS_IRQ_STAT)
         nxt_st.irq_stat = st_ff.irq_stat & ~PWDATA[EV_W-1:0];
      nxt_st.irq_stat = nxt_st.irq_stat | ev;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

      unique case (PADDR)
         OFS_CTRL:
         begin
            rd[CTRL_BRK_OUT] = st_ff.brk_dir_out;
            rd[CTRL_BRK_EN] = st_ff.brk_en;
            rd[CTRL_HOLD_EN] = st_ff.hold_en;
            rd[CTRL_FIR_EN] = st_ff.fir_en;
            rd[CTRL_RST_KIND] = st_ff.rst_kind;
         end
         OFS_STATUS:
         begin
            rd[ST_DBG_EN] = st_ff.dbg_enabled;
            rd[ST_RESET_MODE_SEL_N] = st_ff.reset_mode;
            rd[ST_DBG_RST] = st_ff.dbg_rst;
            rd[ST_BRK_PEND] = st_ff.brk_pend;
            rd[ST_EVT_PEND] = st_ff.evt_pend;
            rd[ST_FIR] = st_ff.fir_active;
            rd[ST_SHUTDOWN] = st_ff.shutdown;
            rd[ST_STRAP_DONE] = st_ff.strap_done;
         end
         OFS_IRQ_STAT: rd[EV_W-1:0] = st_ff.irq_stat;
         OFS_IRQ_MASK: rd[EV_W-1:0] = st_ff.irq_mask;
         OFS_TMR_CLEAR: rd = '0;
         default: mapped = 1'b0;
      endcase
      nxt_st.pready = setup;
      nxt_st.pslverr = setup & ~mapped;
      nxt_st.prdata = (setup && !PWRITE && mapped) ? rd : '0;
   end

   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         st_ff <= ST_RESET;
      else
         st_ff <= nxt_st;
   end

   assign PRDATA = st_ff.prdata;
   assign PREADY = st_ff.pready;
   assign PSLVERR = st_ff.pslverr;
   assign IRQ = st_ff.irq;
   assign BREAK_TRIGGER_IO_N_O = st_ff.trg_o;
   assign BREAK_TRIGGER_IO_N_OE = st_ff.trg_oe;
   assign HOLD_ACK_N_O = st_ff.hold_o;
   assign HOLD_ACK_N_OE = st_ff.hold_oe;
   assign INFRARED_DATA_OUT = st_ff.ir_out;
   assign BREAK_REQ = st_ff.brk_req;
   assign CORE_COLD_RESET_REQ = st_ff.cold_req;
   assign CORE_SOFT_RESET_REQ = st_ff.soft_req;
   assign SHUTDOWN_REQ = st_ff.shutdown;
   assign DBG_UNIT_ACTIVE = st_ff.unit_active;
   assign FIR_ACTIVE = st_ff.fir_active;
   assign DBG_SAMPLE_VALID = st_ff.smp_valid;
   assign DBG_SAMPLE_MODE = st_ff.smp_mode;
   assign DBG_SAMPLE_DATA = st_ff.smp_data;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);

   chk_reset_mode_load: assert property (!st_ff.ur[1] |=> st_ff.dbg_rst == !$past(st_ff.di[1]))
      else $error("Debug reset does not follow reset-mode level");
   chk_break_req_normal: assert property (st_ff.brk_pend && !DEBUG_MODE |=> st_ff.brk_req)
      else $error("Pending break not raised in normal mode");
   chk_break_latch_dbg: assert property (DEBUG_MODE && st_ff.dbg_mode_prev && st_ff.unit_active
      && !st_ff.brk_dir_out && st_ff.brk_en && !st_ff.bk[1] && st_ff.bk[2]
      |=> st_ff.brk_pend && !st_ff.brk_req)
      else $error("Break in debug mode not held pending");
   chk_trig_pulse_len: assert property ($rose(st_ff.trg_state == TRG_LOW) |-> (!st_ff.trg_o)[*8])
      else $error("Trigger pulse shorter than its length");
   chk_merge_events: assert property (BREAKPOINT_MATCH && !DEBUG_MODE && st_ff.trg_oe
      && st_ff.trg_state != TRG_IDLE |=> st_ff.evt_pend)
      else $error("Event during pulse not merged");
   chk_debug_low: assert property (DEBUG_MODE |=> !st_ff.trg_o && !st_ff.evt_pend)
      else $error("Trigger not low or events kept in debug mode");
   chk_no_shutdown_en: assert property (st_ff.dbg_enabled |-> !st_ff.shutdown)
      else $error("Shutdown with debug enabled");
   chk_hold_ack_oe: assert property (st_ff.hold_en && st_ff.strap_done |=> HOLD_ACK_N_OE)
      else $error("Hold acknowledge not driven");
   chk_fir_exclusive: assert property (!(st_ff.fir_active && st_ff.dbg_use))
      else $error("Debug and infrared active together");
   chk_strap_hold: assert property (st_ff.strap_done && $past(st_ff.strap_done)
      |-> $stable(st_ff.dbg_enabled))
      else $error("Strap decision changed after capture");
   chk_irq_level: assert property (IRQ == |(st_ff.irq_stat & st_ff.irq_mask))
      else $error("Interrupt line disagrees with status and mask");
endmodule

// File: dbg_tool_model.sv
// Behavioural debug tool on the serial debug pins of the block.
// Assumes the bench resolves the break wire; link clock idles low, data lines pulled up.
`timescale 1ns/10ps
module dbg_tool_model (
   output logic clk_o,
   output logic mode_o,
   output logic data_o,
   output logic unit_rst_n_o,
   output logic brk_pull_o
);
   initial
   begin
      clk_o = 1'b0;
      mode_o = 1'b1;
      data_o = 1'b1;
      unit_rst_n_o = 1'b0;
      brk_pull_o = 1'b0;
   end
   task automatic set_unit(input logic rst_n, input logic reset_mode_sel_n_n);
      data_o <= reset_mode_sel_n_n;
      unit_rst_n_o <= rst_n;
   endtask
   task automatic send_bits(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         mode_o <= 1'b0;
         data_o <= b[i];
         #80 clk_o <= 1'b1;
         #80 clk_o <= 1'b0;
      end
      mode_o <= 1'b1;
      data_o <= 1'b1;
   endtask
   task automatic pull_break();
      brk_pull_o <= 1'b1;
      #200 brk_pull_o <= 1'b0;
      #200;
   endtask
endmodule

// File: tb.sv
// Self-checking bench for the debug pin block over APB and its pins.
// Assumes the design package and a debug tool model beside it.
`timescale 1ns/10ps
module tb;
   import dbg_pin_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst, psel, penable, pwrite, rtc_rst_n, hold_grant, dbg_out, ir_tx, debug_mode, bp_match, strap_lvl;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        pready, pslverr, irq, brk_o, brk_oe, hold_o, hold_oe, ir_out, brk_req, cold_req, soft_req;
   logic        shut_req, unit_act, fir_act, s_valid, s_mode, s_data, rerr, brk_o_d;
   logic        t_clk, t_mode, t_data, t_urst, t_pull;
   wire         brk_pin = brk_oe ? brk_o : ~t_pull;
   wire         strap_pin = hold_oe ? hold_o : strap_lvl;
   int          fails = 0, checks = 0, cycles = 0, trig_n = 0, base, i;
   logic        exp_q[$];

   always #10 sys_clk = ~sys_clk;

   dbg_tool_model tool (.clk_o(t_clk), .mode_o(t_mode), .data_o(t_data), .unit_rst_n_o(t_urst), .brk_pull_o(t_pull));

   debug_pin_break_trigger #(.SHUTDOWN_CYCLES_P(100)) dut (
      .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .RTC_RESET_N(rtc_rst_n),
      .DBG_SERIAL_CLK(t_clk), .DBG_MODE_SELECT(t_mode), .DBG_SERIAL_IN(t_data), .DBG_UNIT_RESET_N(t_urst),
      .BREAK_TRIGGER_IO_N_I(brk_pin), .BREAK_TRIGGER_IO_N_O(brk_o), .BREAK_TRIGGER_IO_N_OE(brk_oe),
      .DBG_ENABLE_STRAP(strap_pin), .HOLD_ACK_N_O(hold_o), .HOLD_ACK_N_OE(hold_oe), .HOLD_GRANT(hold_grant),
      .DBG_SERIAL_OUT(dbg_out), .IR_TX_DATA(ir_tx), .INFRARED_DATA_OUT(ir_out), .DEBUG_MODE(debug_mode),
      .BREAKPOINT_MATCH(bp_match), .BREAK_REQ(brk_req), .CORE_COLD_RESET_REQ(cold_req),
      .CORE_SOFT_RESET_REQ(soft_req), .SHUTDOWN_REQ(shut_req), .DBG_UNIT_ACTIVE(unit_act),
      .FIR_ACTIVE(fir_act), .DBG_SAMPLE_VALID(s_valid), .DBG_SAMPLE_MODE(s_mode), .DBG_SAMPLE_DATA(s_data));

   task automatic final_report();
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0000_0000);
      chk_word(rdata, exp);
      chk_pin(rerr, err);
   endtask
   task automatic pulse_match();
      @(posedge sys_clk);
      bp_match <= 1'b1;
      @(posedge sys_clk);
      bp_match <= 1'b0;
   endtask

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      brk_o_d <= brk_o;
      if (brk_o_d === 1'b1 && brk_o === 1'b0)
         trig_n <= trig_n + 1;
      if (s_valid === 1'b1)
      begin
         chk_pin(s_mode, 1'b0);
         chk_pin(s_data, exp_q.size() > 0 ? exp_q.pop_front() : ~s_data);
      end
      if (cycles == 20000)
      begin
         fails++;
         final_report();
      end
   end

   initial
   begin
      {nrst, psel, penable, pwrite, rtc_rst_n, hold_grant, dbg_out, ir_tx, debug_mode, bp_match} = '0;
      {paddr, pwdata, strap_lvl} = {8'h00, 32'h0000_0000, 1'b1};
      cyc(3);
      nrst <= 1'b1;
      cyc(1);
      chk_word({28'h0, brk_o, hold_o, irq, shut_req}, 32'h0000_000C);
      rd_chk(8'h20, 32'h0000_0000, 1'b1);
      rd_chk(OFS_IRQ_MASK, 32'h0000_0000, 1'b0);
      tool.set_unit(1'b0, 1'b1);
      rtc_rst_n <= 1'b1;
      cyc(10);
      chk_pin(cold_req, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_word({30'h0, rdata[ST_DBG_EN], rdata[ST_STRAP_DONE]}, 32'h0000_0003);
      tool.set_unit(1'b0, 1'b0);
      cyc(8);
      chk_word({30'h0, cold_req, soft_req}, 32'h0000_0002);
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_RST_KIND);
      cyc(3);
      chk_word({30'h0, cold_req, soft_req}, 32'h0000_0001);
      tool.set_unit(1'b1, 1'b1);
      cyc(8);
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_RST_REL);
      cyc(3);
      chk_word({30'h0, cold_req, soft_req}, 32'h0000_0000);
      strap_lvl <= 1'b0;
      cyc(6);
      chk_pin(unit_act, 1'b1);
      for (i = 7; i >= 0; i--)
         exp_q.push_back(i[0] ^ i[1]);
      tool.send_bits(8'h66);
      cyc(8);
      chk_word(32'(exp_q.size()), 32'h0000_0000);
      ir_tx <= 1'b1;
      cyc(3);
      chk_pin(ir_out, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_BRK_EN);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
      tool.pull_break();
      for (i = 0; i < 10 && brk_req !== 1'b1; i++)
         @(posedge sys_clk);
      chk_pin(brk_req, 1'b1);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0001, 1'b0);
      chk_pin(irq, 1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
      cyc(3);
      chk_pin(irq, 1'b0);
      debug_mode <= 1'b1;
      cyc(3);
      tool.pull_break();
      cyc(10);
      chk_pin(brk_req, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_pin(rdata[ST_BRK_PEND], 1'b1);
      debug_mode <= 1'b0;
      cyc(5);
      chk_pin(brk_req, 1'b1);
      debug_mode <= 1'b1;
      cyc(3);
      debug_mode <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_BRK_OUT);
      cyc(4);
      chk_pin(brk_oe, 1'b1);
      base = trig_n;
      pulse_match();
      cyc(2);
      pulse_match();
      cyc(3);
      pulse_match();
      cyc(40);
      chk_word(32'(trig_n - base), 32'h0000_0002);
      pulse_match();
      pulse_match();
      debug_mode <= 1'b1;
      cyc(3);
      chk_pin(brk_o, 1'b0);
      pulse_match();
      cyc(20);
      chk_pin(brk_o, 1'b0);
      debug_mode <= 1'b0;
      base = trig_n;
      cyc(30);
      chk_pin(brk_o, 1'b1);
      chk_word(32'(trig_n - base), 32'h0000_0000);
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_HOLD_EN);
      hold_grant <= 1'b1;
      cyc(3);
      chk_word({30'h0, hold_oe, hold_o}, 32'h0000_0002);
      hold_grant <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_FIR_EN);
      cyc(4);
      chk_word({29'h0, fir_act, unit_act, ir_out}, 32'h0000_0005);
      chk_pin(shut_req, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      rtc_rst_n <= 1'b0;
      cyc(4);
      rtc_rst_n <= 1'b1;
      cyc(60);
      apb(1'b1, OFS_TMR_CLEAR, 32'h0000_0001);
      cyc(80);
      chk_word({30'h0, shut_req, unit_act}, 32'h0000_0000);
      for (i = 0; i < 150 && shut_req !== 1'b1; i++)
         @(posedge sys_clk);
      chk_pin(shut_req, 1'b1);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0007, 1'b0);
      final_report();
   end
endmodule
